// File: rtl/icc_pkg.sv
package icc_pkg;
  localparam int          NUM_CH      = 2;
  localparam int          TMR_W       = 16;
  localparam int          FIFO_DEPTH  = 4;
  localparam logic [0:0]  ADDR_CON    = 1'h0;
  localparam logic [0:0]  ADDR_BUF    = 1'h1;
  localparam int          CH_ADDR_W   = 1;
  localparam int          ADDR_W      = 2;
  localparam int          BIT_MODE_LO = 0;
  localparam int          BIT_BNE     = 3;
  localparam int          BIT_OV      = 4;
  localparam int          BIT_ICI_LO  = 5;
  localparam int          BIT_TSEL    = 7;
  localparam int          BIT_SIDL    = 13;
  localparam logic [15:0] CON_RST     = 16'h0000;
  localparam logic [15:0] CON_WMASK   = 16'h20E7;
  localparam logic [3:0]  PRE4_MAX    = 4'h3;
  localparam logic [3:0]  PRE16_MAX   = 4'hF;

  typedef enum logic [2:0] {
    ICC_OFF     = 3'h0,
    ICC_EDGE    = 3'h1,
    ICC_FALL    = 3'h2,
    ICC_RISE    = 3'h3,
    ICC_RISE4   = 3'h4,
    ICC_RISE16  = 3'h5,
    ICC_RSVD    = 3'h6,
    ICC_WAKE    = 3'h7
  } icc_mode_t;
endpackage : icc_pkg

// File: rtl/icc_channel.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module icc_channel #(
  parameter int W     = icc_pkg::TMR_W,
  parameter int DEPTH = icc_pkg::FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         pin,
  input  wire logic [W-1:0] timer2,
  input  wire logic [W-1:0] timer3,
  input  wire logic         timer2_on,
  input  wire logic         timer3_on,
  input  wire logic         cpu_idle,
  input  wire logic         cpu_sleep,
  input  wire logic         con_wr,
  input  wire logic [15:0]  con_wdata,
  input  wire logic         buf_rd,
  output logic      [15:0]  con_rdata,
  output logic      [W-1:0] buf_head,
  output logic              irq_pulse,
  output logic              wake_pulse
);
  if (DEPTH < 2 || DEPTH > 16 || W < 1 || W > 16) begin : g_bad_param
    $error("icc_channel: unsupported parameters");
  end

  localparam int CW = $clog2(DEPTH + 1);

  logic [15:0]  con_q;
  logic         pin_q;
  logic [3:0]   pre_q;
  logic [1:0]   evcnt_q;
  logic [W-1:0] mem_q [DEPTH];
  logic [CW-1:0] cnt_q;
  logic         ov_q;

  wire [2:0]   mode     = con_q[icc_pkg::BIT_MODE_LO +: 3];
  wire [1:0]   ici      = con_q[icc_pkg::BIT_ICI_LO +: 2];
  wire         tsel     = con_q[icc_pkg::BIT_TSEL];
  wire         sidl     = con_q[icc_pkg::BIT_SIDL];
  wire         rise     = pin & ~pin_q;
  wire         fall     = ~pin & pin_q;
  wire         tmr_on   = tsel ? timer2_on : timer3_on;
  wire         halted   = cpu_sleep | (cpu_idle & (sidl | ~tmr_on));
  wire         full     = (cnt_q == CW'(DEPTH));
  wire         empty    = (cnt_q == '0);
  wire         pop      = buf_rd & ~empty;
  logic        edge_hit;
  logic        pre_wrap;

  always_comb begin
    edge_hit = 1'b0;
    pre_wrap = 1'b0;
    unique case (icc_pkg::icc_mode_t'(mode))
      icc_pkg::ICC_EDGE:   edge_hit = rise | fall;
      icc_pkg::ICC_FALL:   edge_hit = fall;
      icc_pkg::ICC_RISE:   edge_hit = rise;
      icc_pkg::ICC_RISE4: begin
        pre_wrap = rise && (pre_q == icc_pkg::PRE4_MAX);
        edge_hit = pre_wrap;
      end
      icc_pkg::ICC_RISE16: begin
        pre_wrap = rise && (pre_q == icc_pkg::PRE16_MAX);
        edge_hit = pre_wrap;
      end
      icc_pkg::ICC_WAKE:   edge_hit = rise;
      default:             edge_hit = 1'b0;
    endcase
  end

  wire sleep_evt = cpu_sleep && (mode == icc_pkg::ICC_WAKE) && rise;
  wire cap_evt   = edge_hit && !halted && (mode != icc_pkg::ICC_WAKE);
  wire locked    = ov_q && !empty;
  wire ov_set    = cap_evt && full && !locked && (mode != icc_pkg::ICC_EDGE);
  wire push      = cap_evt && !locked && (!full || pop);
  wire [CW-1:0] cnt_d = cnt_q + CW'(push) - CW'(pop);
  wire [W-1:0] tsample = tsel ? timer2 : timer3;

  wire ici_hit = (evcnt_q == ici);
  // every edge outside a halt interrupts in mode 001
  wire irq_cap = cap_evt && ((mode == icc_pkg::ICC_EDGE) || ici_hit);
  // mode 111 interrupts regardless of timer
  wire irq_wake = edge_hit && (mode == icc_pkg::ICC_WAKE) && (!cpu_sleep || sleep_evt);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      con_q <= icc_pkg::CON_RST;
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
      if (con_wr) begin
        con_q <= con_wdata & icc_pkg::CON_WMASK;
      end
    end
  end

  // prescaler cleared when off or reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
    end else if (mode == icc_pkg::ICC_OFF || (pre_wrap && !halted)) begin
      pre_q <= '0;
    end else if (rise && !halted) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // interrupt counter also resets while off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evcnt_q <= '0;
    end else if (mode == icc_pkg::ICC_OFF || mode == icc_pkg::ICC_EDGE) begin
      evcnt_q <= '0;
    end else if (cap_evt) begin
      evcnt_q <= ici_hit ? 2'h0 : evcnt_q + 2'h1;
    end
  end

  // four-deep fifo, shift on read, same-cycle store
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        mem_q[i] <= mem_q[i + 1];
      end
      if (push && (32'(cnt_q) - (pop ? 1 : 0)) == i) begin
        mem_q[i] <= tsample;
      end
    end
  end

  // count drives not-empty, overflow set outside mode 001, fifth dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      ov_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // clear with the last pop so overflow never shows beside an empty buffer
      if (ov_set) begin
        ov_q <= 1'b1;
      end else if (cnt_d == '0) begin
        ov_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_pulse  <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      // event in idle or sleep wakes
      irq_pulse  <= irq_cap | irq_wake;
      wake_pulse <= (cpu_idle | cpu_sleep) & (irq_cap | irq_wake);
    end
  end

  always_comb begin
    con_rdata = con_q;
    con_rdata[icc_pkg::BIT_BNE] = ~empty;
    con_rdata[icc_pkg::BIT_OV]  = ov_q;
  end
  // empty read yields head word, undefined to software
  assign buf_head = mem_q[0];
endmodule : icc_channel

// File: rtl/icc_top.sv
`timescale 1ns/1ps
module icc_top #(
  parameter int NCH = icc_pkg::NUM_CH
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic [NCH-1:0]           cap_pin,
  input  wire logic [15:0]              timer2_count,
  input  wire logic [15:0]              timer3_count,
  input  wire logic                     timer2_on,
  input  wire logic                     timer3_on,
  input  wire logic                     cpu_idle,
  input  wire logic                     cpu_sleep,
  input  wire logic [NCH-1:0]           channel_irq_enable,
  input  wire logic [icc_pkg::ADDR_W-1:0] addr,
  input  wire logic [15:0]              wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [15:0]              rdata,
  output logic      [NCH-1:0]           channel_irq_flag,
  output logic                          wake_req
);
  if (NCH != icc_pkg::NUM_CH) begin : g_bad_nch
    $error("icc_top: two channels only");
  end

  logic [15:0]    con_rd [NCH];
  logic [15:0]    head   [NCH];
  logic [NCH-1:0] irq_p;
  logic [NCH-1:0] wake_p;

  wire            sel_buf = (addr[0] == icc_pkg::ADDR_BUF);
  wire            sel_ch  = addr[1];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire hit = (sel_ch == 1'(c));
    icc_channel u_ch (
      .clk        (clk),
      .resetn     (resetn),
      .pin        (cap_pin[c]),
      .timer2     (timer2_count),
      .timer3     (timer3_count),
      .timer2_on  (timer2_on),
      .timer3_on  (timer3_on),
      .cpu_idle   (cpu_idle),
      .cpu_sleep  (cpu_sleep),
      .con_wr     (wr && hit && !sel_buf),
      .con_wdata  (wdata),
      .buf_rd     (rd && hit && sel_buf),
      .con_rdata  (con_rd[c]),
      .buf_head   (head[c]),
      .irq_pulse  (irq_p[c]),
      .wake_pulse (wake_p[c])
    );
  end

  wire [15:0] rd_mux = sel_buf ? head[sel_ch] : con_rd[sel_ch];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata            <= '0;
      channel_irq_flag <= '0;
      wake_req         <= 1'b0;
    end else begin
      rdata            <= rd ? rd_mux : 16'h0000;
      channel_irq_flag <= irq_p;
      wake_req         <= |(wake_p & channel_irq_enable);
    end
  end
endmodule : icc_top

// File: verif/icc_props.sv
`timescale 1ns/1ps
module icc_props #(
  parameter int NCH = 2
) (
  input wire logic                         clk,
  input wire logic                         resetn,
  input wire logic [NCH-1:0]               cap_pin,
  input wire logic [icc_pkg::ADDR_W-1:0]   addr,
  input wire logic [15:0]                  wdata,
  input wire logic                         wr,
  input wire logic                         rd,
  input wire logic [15:0]                  rdata,
  input wire logic [NCH-1:0]               channel_irq_flag,
  input wire logic [NCH-1:0]               channel_irq_enable,
  input wire logic                         cpu_idle,
  input wire logic                         cpu_sleep,
  input wire logic                         wake_req
);
  logic [NCH-1:0] pin_q, h1_q, h2_q, h3_q, h4_q;
  // an event may surface up to four cycles after its pin change
  wire  [NCH-1:0] recent = h1_q | h2_q | h3_q | h4_q;
  always_ff @(posedge clk) begin
    pin_q <= cap_pin;
    h1_q  <= cap_pin ^ pin_q;
    h2_q  <= h1_q;
    h3_q  <= h2_q;
    h4_q  <= h3_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside a read answer");
  reset_quiet_a: assert property ($rose(resetn) |-> !wake_req && channel_irq_flag == '0)
    else $error("output active right after reset");
  wake_power_a: assert property (wake_req |-> $past(cpu_idle | cpu_sleep))
    else $error("wake request while awake");
  wake_cause_a: assert property (wake_req |-> |(channel_irq_enable & recent))
    else $error("wake request without enabled pin edge");
  irq_cause0_a: assert property (channel_irq_flag[0] |-> recent[0])
    else $error("channel 0 event without pin edge");
  irq_cause1_a: assert property (channel_irq_flag[1] |-> recent[1])
    else $error("channel 1 event without pin edge");
  ctl_readback_a: assert property (wr && !addr[0] ##1 rd && addr == $past(addr)
    |=> (rdata & 16'h20E7) == ($past(wdata, 2) & 16'h20E7))
    else $error("control readback differs");
  ov_bne_a: assert property (rd && !addr[0] |=> !rdata[4] || rdata[3])
    else $error("overflow shown with empty buffer");
endmodule : icc_props

// File: verif/icc_pin_drv.sv
`timescale 1ns/1ps
module icc_pin_drv (
  input  wire logic        clk,
  input  wire logic [15:0] tmr,
  output logic      [1:0]  cap_pin
);
  initial cap_pin = 2'h0;
  // levels held four cycles so edges never merge; stamp is the count sampled with the rise
  task automatic pulse(input logic ch, output logic [15:0] stamp);
    @(posedge clk);
    cap_pin[ch] <= 1'b1;
    #1 stamp = tmr;
    repeat (4) @(posedge clk);
    cap_pin[ch] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
endmodule : icc_pin_drv

// File: verif/icc_top_tb.sv
`timescale 1ns/1ps
module icc_top_tb;
  logic        clk        = 1'b0;
  logic        resetn     = 1'b0;
  logic        sleep      = 1'b0;
  logic        idle       = 1'b0;
  logic        t3_on      = 1'b1;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [1:0]  addr       = 2'h0;
  logic [15:0] wdata      = 16'h0000;
  logic [15:0] tmr        = 16'h0000;
  logic [15:0] st, rdata;
  logic [1:0]  cap_pin, irq;
  logic        wake;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          irqs       = 0;
  int          wakes      = 0;
  int          cyc        = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    tmr   <= tmr + 16'h0001;
    irqs  <= irqs + int'(irq[0]) + int'(irq[1]);
    wakes <= wakes + int'(wake);
    cyc   <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  icc_top i_icc_top (.clk, .resetn, .cap_pin, .timer2_count(~tmr), .timer3_count(tmr),
    .timer2_on(1'b1), .timer3_on(t3_on), .cpu_idle(idle), .cpu_sleep(sleep),
    .channel_irq_enable(2'h3), .addr, .wdata, .wr, .rd, .rdata,
    .channel_irq_flag(irq), .wake_req(wake));
  icc_pin_drv u_pin (.clk, .tmr, .cap_pin);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rst;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
  endtask : rst
  task automatic rchk(input logic [1:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask : rchk
  task automatic cfg(input logic ch, input logic [15:0] c);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= {ch, 1'b0};
    wdata <= c;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & 16'hFFE7, c & 16'h20E7);
  endtask : cfg
  task automatic run(input logic ch, input logic [15:0] c, input int n, input logic [1:0] s,
                     input int ni);
    int i0;
    rst();
    cfg(ch, c);
    i0 = irqs;
    repeat (n) u_pin.pulse(ch, st);
    rchk({ch, 1'b0}, 16'h0018, {11'h000, s, 3'h0});
    if (ni >= 0) chk(16'(irqs - i0), 16'(ni));
  endtask : run
  task automatic fifo;
    logic [15:0] e [$];
    rst();
    cfg(1'b0, 16'h0003);
    repeat (4) begin
      u_pin.pulse(1'b0, st);
      e.push_back(st);
    end
    u_pin.pulse(1'b0, st);
    rchk(2'h0, 16'h0018, 16'h0018);
    rchk(2'h1, 16'hFFFF, e.pop_front());
    u_pin.pulse(1'b0, st);
    repeat (3) rchk(2'h1, 16'hFFFF, e.pop_front());
    rchk(2'h0, 16'h0018, 16'h0000);
  endtask : fifo
  task automatic presc;
    rst();
    cfg(1'b0, 16'h0004);
    repeat (3) u_pin.pulse(1'b0, st);
    cfg(1'b0, 16'h0000);
    cfg(1'b0, 16'h0004);
    u_pin.pulse(1'b0, st);
    rchk(2'h0, 16'h0008, 16'h0000);
    repeat (3) u_pin.pulse(1'b0, st);
    rchk(2'h0, 16'h0008, 16'h0008);
  endtask : presc
  task automatic wake_run;
    int w0;
    rst();
    // sleep use follows the rising-edge interrupt-only setting
    cfg(1'b1, 16'h0007);
    @(posedge clk);
    sleep <= 1'b1;
    w0 = wakes;
    u_pin.pulse(1'b1, st);
    chk(16'(wakes - w0), 16'h0001);
    sleep <= 1'b0;
  endtask : wake_run
  task automatic idle_run;
    int w0;
    rst();
    @(posedge clk);
    idle  <= 1'b1;
    t3_on <= 1'b0;
    cfg(1'b0, 16'h0003);
    u_pin.pulse(1'b0, st);
    rchk(2'h0, 16'h0008, 16'h0000);
    @(posedge clk);
    t3_on <= 1'b1;
    cfg(1'b0, 16'h2003);
    u_pin.pulse(1'b0, st);
    rchk(2'h0, 16'h0008, 16'h0000);
    cfg(1'b0, 16'h0003);
    w0 = wakes;
    u_pin.pulse(1'b0, st);
    chk(16'(wakes - w0), 16'h0001);
    cfg(1'b0, 16'h0000);
    rchk(2'h1, 16'hFFFF, st);
    @(posedge clk);
    t3_on <= 1'b0;
    cfg(1'b0, 16'h0007);
    w0 = wakes;
    u_pin.pulse(1'b0, st);
    chk(16'(wakes - w0), 16'h0001);
    idle  <= 1'b0;
    t3_on <= 1'b1;
  endtask : idle_run
  task automatic results;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    rst();
    rchk(2'h0, 16'hFFFF, 16'h0000);
    rchk(2'h2, 16'hFFFF, 16'h0000);
    fifo();
    rst();
    cfg(1'b1, 16'h0083);
    u_pin.pulse(1'b1, st);
    rchk(2'h3, 16'hFFFF, ~st);
    presc();
    wake_run();
    idle_run();
    run(1'b0, 16'h0002, 1, 2'h1, 1);
    run(1'b1, 16'h0003, 5, 2'h3, -1);
    run(1'b0, 16'h0004, 3, 2'h0, 0);
    run(1'b0, 16'h0004, 4, 2'h1, 1);
    run(1'b1, 16'h0005, 15, 2'h0, 0);
    run(1'b1, 16'h0005, 16, 2'h1, 1);
    run(1'b0, 16'h0061, 3, 2'h1, 6);
    run(1'b0, 16'h0023, 4, 2'h1, 2);
    run(1'b0, 16'h0000, 2, 2'h0, 0);
    run(1'b0, 16'h0007, 2, 2'h0, 2);
    run(1'b0, 16'h0006, 2, 2'h0, 0);
    results();
  end
endmodule : icc_top_tb
bind icc_top icc_props #(.NCH(NCH)) u_props (.clk, .resetn, .cap_pin, .addr, .wdata, .wr,
  .rd, .rdata, .channel_irq_flag, .channel_irq_enable, .cpu_idle, .cpu_sleep, .wake_req);
